// ### src/cfg_pkg.sv
/*
 Shared constants for the configuration register bank and its host.
 Assumes a byte-wide register space with 7-bit addresses.
*/
package cfg_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam logic [6:0] FAST_SPACE_TOP = 7'h3f;
   localparam logic [6:0] TX_OUTPUT_LEVEL_OFS = 7'h30;
   localparam logic [6:0] CHANNEL_ASSESS_THRESHOLD_OFS = 7'h36;
   localparam logic [6:0] MODEM_CTRL_FIRST_OFS = 7'h46;
   localparam logic [6:0] MODEM_CTRL_SECOND_OFS = 7'h47;
   localparam logic [6:0] RECEIVE_BIAS_CTRL_OFS = 7'h4a;
   localparam logic [6:0] SYNTH_BIAS_CTRL_OFS = 7'h4c;
   localparam logic [6:0] OSCILLATOR_BIAS_CTRL_OFS = 7'h4f;
   localparam logic [6:0] GAIN_LOOP_TARGET_OFS = 7'h53;
   localparam logic [6:0] GAIN_OVERRIDE_EXAMPLE_OFS = 7'h54;
   localparam logic [6:0] CONVERTER_TUNE_A_OFS = 7'h56;
   localparam logic [6:0] CONVERTER_TUNE_B_OFS = 7'h57;
   localparam logic [6:0] CONVERTER_TUNE_C_OFS = 7'h58;
   localparam logic [6:0] ACCESS_DEMO_OFS = 7'h5a;
   localparam logic [7:0] TX_OUTPUT_LEVEL_VAL = 8'h32;
   localparam logic [7:0] CHANNEL_ASSESS_THRESHOLD_VAL = 8'hf8;
   localparam logic [7:0] MODEM_CTRL_FIRST_VAL = 8'h85;
   localparam logic [7:0] MODEM_CTRL_SECOND_VAL = 8'h14;
   localparam logic [7:0] RECEIVE_BIAS_CTRL_VAL = 8'h3f;
   localparam logic [7:0] SYNTH_BIAS_CTRL_VAL = 8'h5a;
   localparam logic [7:0] OSCILLATOR_BIAS_CTRL_VAL = 8'h2b;
   localparam logic [7:0] GAIN_LOOP_TARGET_VAL = 8'h11;
   localparam logic [7:0] CONVERTER_TUNE_A_VAL = 8'h10;
   localparam logic [7:0] CONVERTER_TUNE_B_VAL = 8'h0e;
   localparam logic [7:0] CONVERTER_TUNE_C_VAL = 8'h03;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   localparam logic [7:0] GAIN_OVERRIDE_RESET = 8'h00;
   // Demo register bits: [7] fixed low, [6] fixed high, [5] write-high-only,
   // [4] write-low-only, [3:0] plain read/write.
   localparam int DEMO_FIXED_LOW_BIT = 7;
   localparam int DEMO_FIXED_HIGH_BIT = 6;
   localparam int DEMO_WRITE_HIGH_BIT = 5;
   localparam int DEMO_WRITE_LOW_BIT = 4;
   localparam logic [7:0] ACCESS_DEMO_RESET = 8'h50;
   // Gain override: bit 7 selects manual, bits [6:0] hold the manual value.
   localparam int GAIN_MANUAL_BIT = 7;
   localparam int NUM_TUNE = 11;
   typedef enum logic [1:0] {
      fast_reg_read_instr, fast_reg_write_instr,
      memory_read_instr, memory_write_instr
   } instr_e;
endpackage : cfg_pkg

// ### src/cfg_link_if.sv
/*
 Instruction link between host and register bank.
 Assumes both ends share clk; one instruction per valid pulse.
*/
`timescale 1ns/1ps
interface cfg_link_if;
   logic req_valid;
   cfg_pkg::instr_e req_instr;
   logic [6:0] req_addr;
   logic [7:0] req_wdata;
   logic rsp_valid;
   logic [7:0] rsp_rdata;
   logic rsp_refused;
   modport device (input req_valid, req_instr, req_addr, req_wdata,
      output rsp_valid, rsp_rdata, rsp_refused);
   modport host (output req_valid, req_instr, req_addr, req_wdata,
      input rsp_valid, rsp_rdata, rsp_refused);
endinterface : cfg_link_if

// ### src/effective_select.sv
/*
 Chooses between a generated value and a manual override.
 Assumes both inputs are on the same clock as the reader.
*/
`timescale 1ns/1ps
module effective_select #(
   parameter int WIDTH = 7
) (
   // Sources
   input wire logic manual_en,
   input wire logic [WIDTH-1:0] manual_val,
   input wire logic [WIDTH-1:0] auto_val,
   // Result
   output logic [WIDTH-1:0] effective_val
);
   if (WIDTH < 1) begin : g_width_check
      $error("WIDTH must be positive.");
   end
   assign effective_val = manual_en ? manual_val : auto_val;
endmodule : effective_select

// ### src/cfg_device.sv
/*
 Register bank end: access modes, effective-value read and the tuning
 registers that drive the radio settings.
 Assumes a host on cfg_link_if and a generated gain value from the radio.
*/
`timescale 1ns/1ps
module cfg_device (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Link
   cfg_link_if.device link,
   // Radio side
   input wire logic [6:0] auto_gain,
   input wire logic deepest_sleep_mode,
   output logic [7:0] tx_output_level,
   output logic [7:0] channel_assess_threshold,
   output logic [7:0] modem_ctrl_first,
   output logic [7:0] modem_ctrl_second,
   output logic [6:0] gain_in_use,
   output logic two_zero_symbols_req,
   output logic delimiter_both_req
);
   logic [7:0] tune_reg [cfg_pkg::NUM_TUNE];
   logic [7:0] tune_next [cfg_pkg::NUM_TUNE];
   logic [7:0] gain_ovr_reg, gain_ovr_next;
   logic [6:0] gain_use_reg, gain_use_next;
   logic [7:0] demo_reg, demo_next;
   logic rsp_valid_reg, rsp_valid_next;
   logic [7:0] rsp_rdata_reg, rsp_rdata_next;
   logic rsp_refused_reg, rsp_refused_next;
   logic two_zero_reg, two_zero_next;
   logic delim_both_reg, delim_both_next;
   logic [6:0] gain_eff;
   logic is_wr, is_rd, allowed, wr_ok;
   logic hit_gain, hit_demo;
   logic [7:0] rd_val;
   logic [7:0] w;

   localparam logic [6:0] TUNE_OFS [cfg_pkg::NUM_TUNE] = '{
      cfg_pkg::TX_OUTPUT_LEVEL_OFS, cfg_pkg::CHANNEL_ASSESS_THRESHOLD_OFS,
      cfg_pkg::MODEM_CTRL_FIRST_OFS, cfg_pkg::MODEM_CTRL_SECOND_OFS,
      cfg_pkg::RECEIVE_BIAS_CTRL_OFS, cfg_pkg::SYNTH_BIAS_CTRL_OFS,
      cfg_pkg::OSCILLATOR_BIAS_CTRL_OFS, cfg_pkg::GAIN_LOOP_TARGET_OFS,
      cfg_pkg::CONVERTER_TUNE_A_OFS, cfg_pkg::CONVERTER_TUNE_B_OFS,
      cfg_pkg::CONVERTER_TUNE_C_OFS};

   effective_select #(.WIDTH(7)) gain_sel (
      .manual_en(gain_ovr_reg[cfg_pkg::GAIN_MANUAL_BIT]),
      .manual_val(gain_ovr_reg[6:0]),
      .auto_val(auto_gain),
      .effective_val(gain_eff)
   );

   // Decodes the request and picks the value that a read returns.
   always_comb begin
      w = link.req_wdata;
      is_wr = link.req_valid
         && (link.req_instr == cfg_pkg::fast_reg_write_instr
         || link.req_instr == cfg_pkg::memory_write_instr);
      is_rd = link.req_valid
         && (link.req_instr == cfg_pkg::fast_reg_read_instr
         || link.req_instr == cfg_pkg::memory_read_instr);
      // Fast instructions reach only the fast space.
      allowed = (link.req_instr == cfg_pkg::memory_read_instr)
         || (link.req_instr == cfg_pkg::memory_write_instr)
         || (link.req_addr <= cfg_pkg::FAST_SPACE_TOP);
      wr_ok = is_wr && allowed;
      hit_gain = (link.req_addr == cfg_pkg::GAIN_OVERRIDE_EXAMPLE_OFS);
      hit_demo = (link.req_addr == cfg_pkg::ACCESS_DEMO_OFS);
      rd_val = 8'h00;
      if (hit_gain) begin
         // Low bits read the effective value gain_eff, not the stored override.
         rd_val = {gain_ovr_reg[cfg_pkg::GAIN_MANUAL_BIT], gain_eff};
      end else if (hit_demo) begin
         rd_val = demo_reg;
         rd_val[cfg_pkg::DEMO_FIXED_LOW_BIT] = 1'b0;
         rd_val[cfg_pkg::DEMO_FIXED_HIGH_BIT] = 1'b1;
      end else begin
         for (int i = 0; i < cfg_pkg::NUM_TUNE; i++) begin
            if (link.req_addr == TUNE_OFS[i]) begin
               rd_val = tune_reg[i];
            end
         end
      end
   end

   // Tuning registers; deepest sleep loses them.
   always_comb begin
      tune_next = tune_reg;
      for (int i = 0; i < cfg_pkg::NUM_TUNE; i++) begin
         if (wr_ok && link.req_addr == TUNE_OFS[i]) begin
            tune_next[i] = w;
         end
      end
      if (deepest_sleep_mode) begin
         for (int i = 0; i < cfg_pkg::NUM_TUNE; i++) begin
            tune_next[i] = cfg_pkg::REG_RESET_VAL;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < cfg_pkg::NUM_TUNE; i++) begin
            tune_reg[i] <= cfg_pkg::REG_RESET_VAL;
         end
      end else begin
         tune_reg <= tune_next;
      end
   end

   // Manual gain override and the gain value in use.
   always_comb begin
      gain_ovr_next = gain_ovr_reg;
      if (wr_ok && hit_gain) begin
         gain_ovr_next = w;
      end
      gain_use_next = gain_eff;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gain_ovr_reg <= cfg_pkg::GAIN_OVERRIDE_RESET;
         gain_use_reg <= 7'h00;
      end else begin
         gain_ovr_reg <= gain_ovr_next;
         gain_use_reg <= gain_use_next;
      end
   end

   // Register that shows each bit access mode.
   always_comb begin
      demo_next = demo_reg;
      if (wr_ok && hit_demo) begin
         // Fixed bits keep their value without any error.
         demo_next[3:0] = w[3:0];
         if (w[cfg_pkg::DEMO_WRITE_HIGH_BIT]) begin
            demo_next[cfg_pkg::DEMO_WRITE_HIGH_BIT] = 1'b1;
         end
         if (!w[cfg_pkg::DEMO_WRITE_LOW_BIT]) begin
            demo_next[cfg_pkg::DEMO_WRITE_LOW_BIT] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         demo_reg <= cfg_pkg::ACCESS_DEMO_RESET;
      end else begin
         demo_reg <= demo_next;
      end
   end

   // One answer for each request, in the following cycle.
   always_comb begin
      rsp_valid_next = link.req_valid;
      rsp_refused_next = link.req_valid && !allowed;
      rsp_rdata_next = 8'h00;
      if (is_rd && allowed) begin
         rsp_rdata_next = rd_val;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsp_valid_reg <= 1'b0;
         rsp_rdata_reg <= 8'h00;
         rsp_refused_reg <= 1'b0;
      end else begin
         rsp_valid_reg <= rsp_valid_next;
         rsp_rdata_reg <= rsp_rdata_next;
         rsp_refused_reg <= rsp_refused_next;
      end
   end

   // Modem first 0x85 asks for two zero symbols before sync.
   // Modem second 0x14 drops the both-symbols requirement.
   always_comb begin
      two_zero_next = (tune_reg[2] == cfg_pkg::MODEM_CTRL_FIRST_VAL);
      delim_both_next =
         (tune_reg[3] != cfg_pkg::MODEM_CTRL_SECOND_VAL);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         two_zero_reg <= 1'b0;
         delim_both_reg <= 1'b0;
      end else begin
         two_zero_reg <= two_zero_next;
         delim_both_reg <= delim_both_next;
      end
   end

   assign link.rsp_valid = rsp_valid_reg;
   assign link.rsp_rdata = rsp_rdata_reg;
   assign link.rsp_refused = rsp_refused_reg;
   assign tx_output_level = tune_reg[0];
   assign channel_assess_threshold = tune_reg[1];
   assign modem_ctrl_first = tune_reg[2];
   assign modem_ctrl_second = tune_reg[3];
   assign gain_in_use = gain_use_reg;
   assign two_zero_symbols_req = two_zero_reg;
   assign delimiter_both_req = delim_both_reg;
endmodule : cfg_device

// ### src/cfg_host.sv
/*
 Host end: after reset, or a wake from deepest sleep that arrives while idle, rewrites every
 tuning register over the link, then serves user requests.
 Assumes a register bank on cfg_link_if answering one cycle after a request.
*/
`timescale 1ns/1ps
module cfg_host (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Link
   cfg_link_if.host link,
   // User side
   input wire logic wake,
   input wire logic user_valid,
   input wire cfg_pkg::instr_e user_instr,
   input wire logic [6:0] user_addr,
   input wire logic [7:0] user_wdata,
   output logic user_ready,
   output logic user_done,
   output logic [7:0] user_rdata,
   output logic user_refused
);
   typedef enum {idle_s, init_s, wait_s} host_state_e;
   host_state_e state_reg, state_next;
   logic [3:0] idx_reg, idx_next;
   logic busy_reg, busy_next;
   logic req_valid_reg, req_valid_next;
   cfg_pkg::instr_e req_instr_reg, req_instr_next;
   logic [6:0] req_addr_reg, req_addr_next;
   logic [7:0] req_wdata_reg, req_wdata_next;
   logic done_reg, done_next;
   logic ready_reg, ready_next;
   logic [7:0] rdata_reg, rdata_next;
   logic refused_reg, refused_next;

   localparam logic [14:0] TABLE [cfg_pkg::NUM_TUNE] = '{
      {cfg_pkg::TX_OUTPUT_LEVEL_OFS, cfg_pkg::TX_OUTPUT_LEVEL_VAL},
      {cfg_pkg::CHANNEL_ASSESS_THRESHOLD_OFS,
         cfg_pkg::CHANNEL_ASSESS_THRESHOLD_VAL},
      {cfg_pkg::MODEM_CTRL_FIRST_OFS, cfg_pkg::MODEM_CTRL_FIRST_VAL},
      {cfg_pkg::MODEM_CTRL_SECOND_OFS, cfg_pkg::MODEM_CTRL_SECOND_VAL},
      {cfg_pkg::RECEIVE_BIAS_CTRL_OFS, cfg_pkg::RECEIVE_BIAS_CTRL_VAL},
      {cfg_pkg::SYNTH_BIAS_CTRL_OFS, cfg_pkg::SYNTH_BIAS_CTRL_VAL},
      {cfg_pkg::OSCILLATOR_BIAS_CTRL_OFS, cfg_pkg::OSCILLATOR_BIAS_CTRL_VAL},
      {cfg_pkg::GAIN_LOOP_TARGET_OFS, cfg_pkg::GAIN_LOOP_TARGET_VAL},
      {cfg_pkg::CONVERTER_TUNE_A_OFS, cfg_pkg::CONVERTER_TUNE_A_VAL},
      {cfg_pkg::CONVERTER_TUNE_B_OFS, cfg_pkg::CONVERTER_TUNE_B_VAL},
      {cfg_pkg::CONVERTER_TUNE_C_OFS, cfg_pkg::CONVERTER_TUNE_C_VAL}};

   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      busy_next = busy_reg;
      req_valid_next = 1'b0;
      req_instr_next = req_instr_reg;
      req_addr_next = req_addr_reg;
      req_wdata_next = req_wdata_reg;
      case (state_reg)
         idle_s: begin
            if (wake) begin
               state_next = init_s;
               idx_next = 4'h0;
            end else if (user_valid) begin
               req_valid_next = 1'b1;
               req_instr_next = user_instr;
               req_addr_next = user_addr;
               req_wdata_next = user_wdata;
               busy_next = 1'b1;
               state_next = wait_s;
            end
         end
         init_s: begin
            // Every tuning register is written again on each wake taken in idle_s.
            req_valid_next = 1'b1;
            req_instr_next = cfg_pkg::memory_write_instr;
            req_addr_next = TABLE[idx_reg][14:8];
            req_wdata_next = TABLE[idx_reg][7:0];
            busy_next = 1'b0;
            state_next = wait_s;
         end
         wait_s: begin
            if (link.rsp_valid) begin
               if (busy_reg || idx_reg == 4'(cfg_pkg::NUM_TUNE - 1)) begin
                  state_next = idle_s;
               end else begin
                  idx_next = idx_reg + 4'h1;
                  state_next = init_s;
               end
            end
         end
         default: state_next = idle_s;
      endcase
   end

   // User-side answer and readiness.
   always_comb begin
      done_next = link.rsp_valid && busy_reg && state_reg == wait_s;
      ready_next = state_next == idle_s
         && !(state_reg == idle_s && user_valid);
      rdata_next = rdata_reg;
      refused_next = refused_reg;
      if (link.rsp_valid && busy_reg) begin
         rdata_next = link.rsp_rdata;
         refused_next = link.rsp_refused;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= init_s;
         idx_reg <= 4'h0;
         busy_reg <= 1'b0;
         req_valid_reg <= 1'b0;
         req_instr_reg <= cfg_pkg::fast_reg_read_instr;
         req_addr_reg <= 7'h00;
         req_wdata_reg <= 8'h00;
         done_reg <= 1'b0;
         ready_reg <= 1'b0;
         rdata_reg <= 8'h00;
         refused_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         busy_reg <= busy_next;
         req_valid_reg <= req_valid_next;
         req_instr_reg <= req_instr_next;
         req_addr_reg <= req_addr_next;
         req_wdata_reg <= req_wdata_next;
         done_reg <= done_next;
         ready_reg <= ready_next;
         rdata_reg <= rdata_next;
         refused_reg <= refused_next;
      end
   end

   assign link.req_valid = req_valid_reg;
   assign link.req_instr = req_instr_reg;
   assign link.req_addr = req_addr_reg;
   assign link.req_wdata = req_wdata_reg;
   assign user_ready = ready_reg;
   assign user_done = done_reg;
   assign user_rdata = rdata_reg;
   assign user_refused = refused_reg;
endmodule : cfg_host

// ### sim/cfg_link_sva.sv
/*
 Checker for the link between host and register bank.
 Assumes the cfg_link_if signals on one clock with synchronous reset.
*/
`timescale 1ns/1ps
module cfg_link_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Link
   input wire logic req_valid,
   input wire cfg_pkg::instr_e req_instr,
   input wire logic [6:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_rdata,
   input wire logic rsp_refused
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic fast;
   logic wr;
   assign fast = req_instr inside {cfg_pkg::fast_reg_read_instr,
      cfg_pkg::fast_reg_write_instr};
   assign wr = req_instr inside {cfg_pkg::memory_write_instr,
      cfg_pkg::fast_reg_write_instr};
   answer_next_a: assert property (req_valid |=> rsp_valid)
      else $error("no answer one cycle after request");
   answer_cause_a: assert property (rsp_valid |-> $past(req_valid))
      else $error("answer without request");
   one_request_a: assert property (req_valid |=> !req_valid)
      else $error("request while one is open");
   fast_refused_a: assert property (req_valid && fast &&
      req_addr > cfg_pkg::FAST_SPACE_TOP |=> rsp_refused)
      else $error("fast access outside fast space taken");
   access_taken_a: assert property (req_valid &&
      !(fast && req_addr > cfg_pkg::FAST_SPACE_TOP) |=> !rsp_refused)
      else $error("legal access refused");
   refuse_pulse_a: assert property (rsp_refused |-> rsp_valid)
      else $error("refusal outside an answer");
   write_quiet_a: assert property (req_valid && wr &&
      req_wdata != 8'h00 |=> rsp_valid && rsp_rdata == 8'h00)
      else $error("write answer carries data");
   fixed_bits_a: assert property (req_valid &&
      req_instr == cfg_pkg::memory_read_instr &&
      req_addr == cfg_pkg::ACCESS_DEMO_OFS |=> rsp_rdata[7:6] == 2'b01)
      else $error("fixed bits read wrong");
endmodule : cfg_link_sva

// ### sim/testbench.sv
/*
 Self-checking bench: host and register bank joined by cfg_link_if.
 Assumes the host rewrites tuning after reset and after each wake taken while idle.
*/
`timescale 1ns/1ps
module testbench;
   localparam cfg_pkg::instr_e mr = cfg_pkg::memory_read_instr;
   localparam cfg_pkg::instr_e mw = cfg_pkg::memory_write_instr;
   localparam cfg_pkg::instr_e fr = cfg_pkg::fast_reg_read_instr;
   localparam cfg_pkg::instr_e fw = cfg_pkg::fast_reg_write_instr;
   localparam logic [14:0] tune [11] = '{{7'h30, 8'h32}, {7'h36, 8'hf8},
      {7'h46, 8'h85}, {7'h47, 8'h14}, {7'h4a, 8'h3f}, {7'h4c, 8'h5a},
      {7'h4f, 8'h2b}, {7'h53, 8'h11}, {7'h56, 8'h10}, {7'h57, 8'h0e},
      {7'h58, 8'h03}};
   logic clk, sys_rst, wake, user_valid, deepest_sleep_mode;
   cfg_pkg::instr_e user_instr;
   logic [6:0] user_addr, auto_gain, gain_in_use;
   logic [7:0] user_wdata, user_rdata, tx_output_level;
   logic [7:0] channel_assess_threshold, modem_ctrl_first;
   logic [7:0] modem_ctrl_second;
   logic user_ready, user_done, user_refused;
   logic two_zero_symbols_req, delimiter_both_req;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   cfg_link_if link ();
   cfg_device cfg_device_i (.clk, .sys_rst, .link, .auto_gain,
      .deepest_sleep_mode, .tx_output_level, .channel_assess_threshold,
      .modem_ctrl_first, .modem_ctrl_second, .gain_in_use,
      .two_zero_symbols_req, .delimiter_both_req);
   cfg_host cfg_host_i (.clk, .sys_rst, .link, .wake, .user_valid,
      .user_instr, .user_addr, .user_wdata, .user_ready, .user_done,
      .user_rdata, .user_refused);
   cfg_link_sva cfg_link_sva_i (.clk, .sys_rst,
      .req_valid(link.req_valid), .req_instr(link.req_instr),
      .req_addr(link.req_addr), .req_wdata(link.req_wdata),
      .rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata),
      .rsp_refused(link.rsp_refused));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wait_ready(input logic lvl);
      int n;
      n = 0;
      while (user_ready !== lvl && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk("user_ready", {7'h00, lvl}, {7'h00, user_ready});
   endtask : wait_ready
   task automatic op(input cfg_pkg::instr_e i, input logic [6:0] a,
         input logic [7:0] d);
      int n;
      wait_ready(1'b1);
      user_valid <= 1'b1;
      user_instr <= i;
      user_addr <= a;
      user_wdata <= d;
      @(posedge clk);
      user_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (user_done !== 1'b1 && n < 20);
      chk("user_done", 8'h01, {7'h00, user_done});
   endtask : op
   task automatic rd(input cfg_pkg::instr_e i, input logic [6:0] a,
         input logic [7:0] e, input logic rf);
      op(i, a, 8'h00);
      chk("refused", {7'h00, rf}, {7'h00, user_refused});
      if (!rf) begin
         chk("read data", e, user_rdata);
      end
   endtask : rd
   task automatic tune_check();
      for (int i = 0; i < 11; i++) begin
         rd(mr, tune[i][14:8], tune[i][7:0], 1'b0);
      end
      chk("tx level", 8'h32, tx_output_level);
      chk("assess", 8'hf8, channel_assess_threshold);
      chk("modem first", 8'h85, modem_ctrl_first);
      chk("modem second", 8'h14, modem_ctrl_second);
      chk("two zero", 8'h01, {7'h00, two_zero_symbols_req});
      chk("both delim", 8'h00, {7'h00, delimiter_both_req});
   endtask : tune_check
   task automatic access_modes();
      rd(mr, 7'h5a, 8'h50, 1'b0);
      op(mw, 7'h5a, 8'h0f);
      rd(mr, 7'h5a, 8'h4f, 1'b0);
      op(mw, 7'h5a, 8'hff);
      rd(mr, 7'h5a, 8'h6f, 1'b0);
      op(mw, 7'h5a, 8'h00);
      rd(mr, 7'h5a, 8'h60, 1'b0);
   endtask : access_modes
   task automatic effective();
      op(mw, 7'h54, 8'h05);
      rd(mr, 7'h54, 8'h2a, 1'b0);
      chk("gain", 8'h2a, {1'b0, gain_in_use});
      op(mw, 7'h54, 8'h85);
      auto_gain <= 7'h11;
      rd(mr, 7'h54, 8'h85, 1'b0);
      chk("gain", 8'h05, {1'b0, gain_in_use});
      op(mw, 7'h54, 8'h00);
      rd(mr, 7'h54, 8'h11, 1'b0);
   endtask : effective
   task automatic spaces();
      rd(fr, 7'h30, 8'h32, 1'b0);
      rd(fr, 7'h46, 8'h00, 1'b1);
      op(fw, 7'h47, 8'hff);
      chk("refused", 8'h01, {7'h00, user_refused});
      rd(mr, 7'h47, 8'h14, 1'b0);
      op(fw, 7'h36, 8'haa);
      rd(mr, 7'h36, 8'haa, 1'b0);
      op(mw, 7'h30, 8'h40);
      rd(fr, 7'h30, 8'h40, 1'b0);
      rd(mr, 7'h7f, 8'h00, 1'b0);
   endtask : spaces
   task automatic sleep_wake();
      deepest_sleep_mode <= 1'b1;
      repeat (3) @(posedge clk);
      chk("slept level", 8'h00, tx_output_level);
      chk("slept two zero", 8'h00, {7'h00, two_zero_symbols_req});
      chk("slept both", 8'h01, {7'h00, delimiter_both_req});
      deepest_sleep_mode <= 1'b0;
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      wait_ready(1'b0);
      wait_ready(1'b1);
      tune_check();
   endtask : sleep_wake
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         $display("unexpected cycles exp 4999 got %0d", cycles);
         report_and_stop();
      end
   end
   initial begin
      sys_rst = 1'b1;
      wake = 1'b0;
      user_valid = 1'b0;
      user_instr = mr;
      user_addr = 7'h00;
      user_wdata = 8'h00;
      auto_gain = 7'h2a;
      deepest_sleep_mode = 1'b0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      wait_ready(1'b1);
      tune_check();
      access_modes();
      effective();
      spaces();
      sleep_wake();
      report_and_stop();
   end
endmodule : testbench
